// File: rtl/lpmc_top.sv
// low power mode controller: mode sequencing, gating and register file
`timescale 1ns/1ps
module lpmc_top import lpmc_pkg::*; (
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    input  wire logic        POR_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        CORE_WAIT,
    input  wire logic        CORE_WAIT_EVENT,
    input  wire logic        CORE_DEEP_SLEEP,
    input  wire logic        CORE_SLEEP_ON_EXIT,
    input  wire logic        CORE_IN_ISR,
    input  wire logic        IRQ_PENDING,
    input  wire logic        EVENT_IN,
    input  wire logic [1:0]  WAKE_PIN,
    input  wire logic        RTC_ALARM,
    input  wire logic        RTC_EVENT,
    input  wire logic        EXT_RESET_PIN_N,
    input  wire logic        WATCHDOG_RESET,
    output logic             CORE_CLK_EN,
    output logic             DOMAIN_CLK_EN,
    output logic             HSI_OSC_EN,
    output logic             HSE_OSC_EN,
    output logic             REG_LOWPOWER,
    output logic             CORE_POWER_EN,
    output logic             CHIP_RESET_REQ,
    output logic             WAKE_REQ,
    output logic             WAKE_TO_ISR,
    output logic             RTC_WRITE_EN
);
    lpmc_state_t state;
    lpmc_state_t next_state;
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic        entered_wfe;
    logic        stop_lp;
    logic        sbsel;
    logic        rtc_we;
    logic        wake_flag;
    logic        sb_flag;
    logic [1:0]  wake_cfg;
    logic [1:0]  wufc_pipe;
    logic [5:0]  pin_s1;
    logic [5:0]  pin_s2;
    logic [5:0]  pin_s3;
    logic        wr_ctrl;
    logic        wr_sts;
    logic        woke;
    logic        sb_wake;
    logic        pin_rise;
    logic        bus_end;

    function automatic logic addr_ok(input logic [11:0] a);
        return (a == LPMC_OFS_CTRL) || (a == LPMC_OFS_STS);
    endfunction

    function automatic logic in_deep(input lpmc_state_t s);
        return (s == LPMC_STOP) || (s == LPMC_STOP_WK)
            || (s == LPMC_STANDBY) || (s == LPMC_SB_EXIT);
    endfunction

    // pins cross into the clock domain through two flops
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pin_s1 <= PIN_SYNC_RESET;
            pin_s2 <= PIN_SYNC_RESET;
            pin_s3 <= PIN_SYNC_RESET;
        end else begin
            pin_s1 <= {WATCHDOG_RESET, EXT_RESET_PIN_N, RTC_EVENT, RTC_ALARM, WAKE_PIN};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    assign pin_rise = |(pin_s2[1:0] & ~pin_s3[1:0] & wake_cfg);
    assign sb_wake  = pin_rise || pin_s2[2] || pin_s2[3]
                   || !pin_s2[4] || pin_s2[5];

    // core signals share this clock, so no synchroniser
    assign woke = entered_wfe ? EVENT_IN : IRQ_PENDING;

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        unique case (state)
            LPMC_RUN: begin
                if (CORE_WAIT) begin
                    if (!CORE_DEEP_SLEEP) begin
                        if (CORE_SLEEP_ON_EXIT && CORE_IN_ISR)
                            next_state = LPMC_ISR_EXIT;
                        else
                            next_state = LPMC_SLEEP;
                    end else if (!sbsel) begin
                        next_state = LPMC_STOP;
                    end else if (!wake_flag) begin
                        next_state = LPMC_STANDBY;
                    end
                end
            end
            LPMC_ISR_EXIT: begin
                if (!CORE_IN_ISR)
                    next_state = LPMC_SLEEP;
            end
            LPMC_SLEEP: begin
                if (woke)
                    next_state = LPMC_RUN;
            end
            LPMC_STOP: begin
                if (woke) begin
                    next_state = LPMC_STOP_WK;
                    next_cnt   = stop_lp ? 16'(HSI_CYC + REG_CYC) : HSI_CYC;
                end
            end
            LPMC_STOP_WK: begin
                next_cnt = cnt - CNT_ONE;
                if (cnt == CNT_ONE)
                    next_state = LPMC_RUN;
            end
            LPMC_STANDBY: begin
                if (sb_wake) begin
                    next_state = LPMC_SB_EXIT;
                    next_cnt   = RST_CYC;
                end
            end
            LPMC_SB_EXIT: begin
                next_cnt = cnt - CNT_ONE;
                if (cnt == CNT_ONE)
                    next_state = LPMC_RUN;
            end
            default: next_state = LPMC_RUN;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state       <= LPMC_RUN;
            cnt         <= '0;
            entered_wfe <= 1'b0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            if (state == LPMC_RUN && CORE_WAIT)
                entered_wfe <= CORE_WAIT_EVENT;
        end
    end

    // gating outputs follow the next state so every pin is a flop
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            CORE_CLK_EN    <= 1'b1;
            DOMAIN_CLK_EN  <= 1'b1;
            HSI_OSC_EN     <= 1'b1;
            HSE_OSC_EN     <= 1'b1;
            REG_LOWPOWER   <= 1'b0;
            CORE_POWER_EN  <= 1'b1;
            CHIP_RESET_REQ <= 1'b0;
            WAKE_REQ       <= 1'b0;
            WAKE_TO_ISR    <= 1'b0;
        end else begin
            CORE_CLK_EN    <= next_state == LPMC_RUN || next_state == LPMC_ISR_EXIT;
            DOMAIN_CLK_EN  <= !in_deep(next_state);
            HSI_OSC_EN     <= !in_deep(next_state) || next_state == LPMC_STOP_WK;
            HSE_OSC_EN     <= !in_deep(next_state);
            REG_LOWPOWER   <= next_state == LPMC_STOP && stop_lp;
            CORE_POWER_EN  <= next_state != LPMC_STANDBY;
            CHIP_RESET_REQ <= next_state == LPMC_SB_EXIT;
            WAKE_REQ       <= next_state == LPMC_RUN && state != LPMC_RUN;
            // interrupt wake sends core to handler; event wake resumes in line
            WAKE_TO_ISR    <= next_state == LPMC_RUN && state != LPMC_RUN
                           && !entered_wfe && state != LPMC_SB_EXIT;
        end
    end

    assign bus_end = PSEL && PENABLE && PREADY;
    assign wr_ctrl = bus_end && PWRITE && PADDR == LPMC_OFS_CTRL;
    assign wr_sts  = bus_end && PWRITE && PADDR == LPMC_OFS_STS;

    // control register, also wiped when leaving standby
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            stop_lp <= 1'b0;
            sbsel   <= 1'b0;
            rtc_we  <= 1'b0;
        end else if (state == LPMC_SB_EXIT) begin
            stop_lp <= 1'b0;
            sbsel   <= 1'b0;
            rtc_we  <= 1'b0;
        end else if (wr_ctrl) begin
            stop_lp <= PWDATA[CTRL_LP_BIT];
            sbsel   <= PWDATA[CTRL_SBSEL_BIT];
            rtc_we  <= PWDATA[CTRL_RTCWE_BIT];
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N)
            RTC_WRITE_EN <= 1'b0;
        else
            RTC_WRITE_EN <= state != LPMC_SB_EXIT && (wr_ctrl ? PWDATA[CTRL_RTCWE_BIT] : rtc_we);
    end

    // wake flag: clear lands two cycles after the write, a set wins over it
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wufc_pipe <= 2'h0;
            wake_flag <= 1'b0;
            wake_cfg  <= 2'h0;
        end else begin
            wufc_pipe <= {wufc_pipe[0], wr_ctrl && PWDATA[CTRL_WUFC_BIT]};
            if (|(pin_s2[1:0] & wake_cfg) || pin_s2[2])
                wake_flag <= 1'b1;
            else if (wufc_pipe[1])
                wake_flag <= 1'b0;
            if (wr_sts)
                wake_cfg <= PWDATA[STS_WCFG_HI:STS_WCFG_LO];
        end
    end

    // standby flag lives on power reset only, so it survives standby wake
    always_ff @(posedge SYS_CLK or negedge POR_N) begin
        if (!POR_N)
            sb_flag <= 1'b0;
        else if (next_state == LPMC_STANDBY)
            sb_flag <= 1'b1;
        else if (wr_ctrl && PWDATA[CTRL_SBFC_BIT])
            sb_flag <= 1'b0;
    end

    // bus: status read holds ready low one extra access cycle
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= LPMC_WORD_ZERO;
        end else if (PSEL && !PENABLE) begin
            PREADY  <= PWRITE || PADDR != LPMC_OFS_STS;
            PSLVERR <= !addr_ok(PADDR);
            PRDATA  <= LPMC_WORD_ZERO;
            if (!PWRITE && PADDR == LPMC_OFS_CTRL) begin
                PRDATA[CTRL_LP_BIT]    <= stop_lp;
                PRDATA[CTRL_SBSEL_BIT] <= sbsel;
                PRDATA[CTRL_RTCWE_BIT] <= rtc_we;
            end
        end else if (PSEL && PENABLE && !PREADY) begin
            PREADY <= 1'b1;
            PRDATA <= LPMC_WORD_ZERO;
            PRDATA[STS_WEF_BIT] <= wake_flag;
            PRDATA[STS_SBF_BIT] <= sb_flag;
            PRDATA[STS_WCFG_HI:STS_WCFG_LO] <= wake_cfg;
        end else begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end
    end
endmodule

// File: inc/lpmc_pkg.sv
// constants, register map and state codes for the low power mode controller
package lpmc_pkg;
    localparam logic [11:0] LPMC_OFS_CTRL = 12'h000;
    localparam logic [11:0] LPMC_OFS_STS  = 12'h004;
    localparam int CTRL_LP_BIT   = 0;
    localparam int CTRL_SBSEL_BIT = 1;
    localparam int CTRL_WUFC_BIT = 2;
    localparam int CTRL_SBFC_BIT = 3;
    localparam int CTRL_RTCWE_BIT = 8;
    localparam int STS_WEF_BIT   = 0;
    localparam int STS_SBF_BIT   = 1;
    localparam int STS_WCFG_LO   = 8;
    localparam int STS_WCFG_HI   = 9;
    localparam logic [31:0] LPMC_WORD_ZERO = 32'h0000_0000;
    localparam int CLK_PERIOD_NS  = 20;
    localparam int HSI_STARTUP_NS = 2000;
    localparam int REG_RECOVER_NS = 5000;
    localparam int RESET_TIME_NS  = 1000;
    localparam logic [15:0] HSI_CYC =
        16'((HSI_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] REG_CYC =
        16'((REG_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] RST_CYC =
        16'((RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] CNT_ONE = 16'h0001;
    // pin sync vector: {watchdog, reset pin n, rtc event, rtc alarm, wake pins}
    localparam logic [5:0] PIN_SYNC_RESET = 6'h10;
    typedef enum logic [2:0] {
        LPMC_RUN      = 3'b000,
        LPMC_ISR_EXIT = 3'b001,
        LPMC_SLEEP    = 3'b010,
        LPMC_STOP     = 3'b011,
        LPMC_STOP_WK  = 3'b100,
        LPMC_STANDBY  = 3'b101,
        LPMC_SB_EXIT  = 3'b110
    } lpmc_state_t;
endpackage

// File: bench/lpmc_chk.sv
// concurrent checks on the low power mode controller ports
`timescale 1ns/1ps
module lpmc_chk import lpmc_pkg::*; (
    input wire logic        SYS_CLK,
    input wire logic        RST_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic        PREADY,
    input wire logic        CORE_WAIT,
    input wire logic        CORE_DEEP_SLEEP,
    input wire logic        CORE_SLEEP_ON_EXIT,
    input wire logic        CORE_CLK_EN,
    input wire logic        DOMAIN_CLK_EN,
    input wire logic        HSI_OSC_EN,
    input wire logic        REG_LOWPOWER,
    input wire logic        CORE_POWER_EN,
    input wire logic        WAKE_REQ,
    input wire logic        WAKE_TO_ISR,
    input wire logic        RTC_WRITE_EN
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    wire logic wr_ctrl = PSEL && PENABLE && PREADY && PWRITE && PADDR == LPMC_OFS_CTRL;
    a_sts_extra: assert property (PSEL && !PENABLE && !PWRITE && PADDR == LPMC_OFS_STS
        |=> !PREADY ##1 PREADY) else $error("status read timing");
    a_rtc_enable: assert property (wr_ctrl |=> RTC_WRITE_EN == $past(PWDATA[CTRL_RTCWE_BIT]))
        else $error("rtc enable");
    a_sleep_entry: assert property (CORE_WAIT && CORE_CLK_EN && !CORE_DEEP_SLEEP
        && !CORE_SLEEP_ON_EXIT |=> !CORE_CLK_EN && DOMAIN_CLK_EN) else $error("sleep entry");
    a_stop_gates: assert property (!HSI_OSC_EN |-> !DOMAIN_CLK_EN && !CORE_CLK_EN)
        else $error("stop gating");
    a_reg_lowpower: assert property (REG_LOWPOWER |-> !HSI_OSC_EN && CORE_POWER_EN)
        else $error("regulator mode");
    a_power_off: assert property (!CORE_POWER_EN |-> !DOMAIN_CLK_EN && !HSI_OSC_EN)
        else $error("standby gating");
    a_wake_pulse: assert property (WAKE_REQ |=> !WAKE_REQ) else $error("wake pulse");
    a_isr_wake: assert property (WAKE_TO_ISR |-> WAKE_REQ && CORE_CLK_EN)
        else $error("handler wake");
    cover property (WAKE_TO_ISR);
    cover property (REG_LOWPOWER);
    cover property (!CORE_POWER_EN);
endmodule
bind lpmc_top lpmc_chk i_lpmc_chk (.*);

// File: bench/lpmc_core_model.sv
// core side model: wait marks and a pending interrupt
`timescale 1ns/1ps
module lpmc_core_model (
    input  wire logic SYS_CLK,
    input  wire logic go,
    input  wire logic irq_req,
    input  wire logic WAKE_REQ,
    output logic      CORE_WAIT = 1'h0,
    output logic      IRQ_PENDING = 1'h0
);
    always @(posedge SYS_CLK) begin
        CORE_WAIT <= go;
        // held until served, so a slow wake still sees it
        if (irq_req) begin
            IRQ_PENDING <= 1'h1;
        end else if (WAKE_REQ) begin
            IRQ_PENDING <= 1'h0;
        end
    end
endmodule

// File: bench/tb.sv
// self-checking bench for the low power mode controller
`timescale 1ns/1ps
module tb import lpmc_pkg::*;;
    logic        SYS_CLK, RST_N, POR_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, q;
    logic        CORE_WAIT, CORE_WAIT_EVENT, CORE_DEEP_SLEEP, CORE_SLEEP_ON_EXIT, CORE_IN_ISR;
    logic        IRQ_PENDING, EVENT_IN, RTC_ALARM, RTC_EVENT, WATCHDOG_RESET, EXT_RESET_PIN_N;
    logic [1:0]  WAKE_PIN;
    logic        CORE_CLK_EN, DOMAIN_CLK_EN, HSI_OSC_EN, HSE_OSC_EN, REG_LOWPOWER, go;
    logic        CORE_POWER_EN, CHIP_RESET_REQ, WAKE_REQ, WAKE_TO_ISR, RTC_WRITE_EN, irq_req;
    int          n_fail = 0, total_checks = 0, lat, n;
    lpmc_top i_lpmc_top (.*);
    lpmc_core_model i_lpmc_core_model (.*);
    initial begin
        SYS_CLK = 1'h0;
        forever #10 SYS_CLK = ~SYS_CLK;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(negedge SYS_CLK);
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = {2'h2, w, a, d};
        @(negedge SYS_CLK);
        PENABLE = 1'h1;
        for (lat = 0; lat < 8; lat++) begin
            @(posedge SYS_CLK);
            if (PREADY === 1'h1) break;
        end
        {q, err} = {PRDATA, PSLVERR};
        chk(lat < 8, 1'h1);
        @(negedge SYS_CLK);
        {PSEL, PENABLE} = 2'h0;
    endtask
    task automatic wait_hi(ref logic s, input int lim);
        for (n = 0; n < lim && s !== 1'h1; n++) @(negedge SYS_CLK);
        chk(n < lim, 1'h1);
    endtask
    task automatic pulse(ref logic s);
        s = 1'h1;
        @(negedge SYS_CLK);
        s = 1'h0;
    endtask
    // wait mark lands one cycle after go, then the mode settles
    task automatic core_wait(input logic ev, input logic dp);
        @(negedge SYS_CLK);
        {CORE_WAIT_EVENT, CORE_DEEP_SLEEP} = {ev, dp};
        pulse(go);
        repeat (2) @(negedge SYS_CLK);
    endtask
    task automatic t_regs;
        chk(RTC_WRITE_EN, 1'h0);
        // run mode keeps both clocks and both oscillators enabled
        chk({CORE_CLK_EN, DOMAIN_CLK_EN, HSI_OSC_EN, HSE_OSC_EN}, 4'hF);
        apb(1'h0, LPMC_OFS_CTRL, LPMC_WORD_ZERO);
        chk(q, LPMC_WORD_ZERO);
        apb(1'h0, LPMC_OFS_STS, LPMC_WORD_ZERO);
        chk(lat, 32'h1);
        chk(q[9:8], 2'h0);
        apb(1'h0, 12'h008, LPMC_WORD_ZERO);
        chk(err, 1'h1);
        apb(1'h1, LPMC_OFS_CTRL, 32'h0000_0100);
        chk(RTC_WRITE_EN, 1'h1);
    endtask
    task automatic t_sleep;
        core_wait(1'h0, 1'h0);
        chk({CORE_CLK_EN, DOMAIN_CLK_EN, HSI_OSC_EN}, 3'h3);
        pulse(EVENT_IN);
        repeat (3) @(negedge SYS_CLK);
        chk(CORE_CLK_EN, 1'h0);
        pulse(irq_req);
        wait_hi(WAKE_REQ, 20);
        chk({CORE_CLK_EN, WAKE_TO_ISR}, 2'h3);
    endtask
    task automatic t_stop;
        apb(1'h1, LPMC_OFS_CTRL, 32'h0000_0001);
        core_wait(1'h1, 1'h1);
        chk({REG_LOWPOWER, HSI_OSC_EN, HSE_OSC_EN, DOMAIN_CLK_EN}, 4'h8);
        pulse(EVENT_IN);
        wait_hi(WAKE_REQ, 1000);
        chk(n + 2 >= HSI_CYC + REG_CYC, 1'h1);
        chk({WAKE_TO_ISR, DOMAIN_CLK_EN, HSE_OSC_EN}, 3'h3);
    endtask
    task automatic t_standby;
        apb(1'h1, LPMC_OFS_STS, 32'h0000_0100);
        apb(1'h1, LPMC_OFS_CTRL, 32'h0000_0102);
        core_wait(1'h0, 1'h1);
        chk({CORE_POWER_EN, CORE_CLK_EN}, 2'h0);
        WAKE_PIN = 2'h2;
        repeat (8) @(negedge SYS_CLK);
        chk(CORE_POWER_EN, 1'h0);
        WAKE_PIN = 2'h3;
        wait_hi(CHIP_RESET_REQ, 10);
        wait_hi(WAKE_REQ, 200);
        chk(n >= RST_CYC, 1'h1);
        apb(1'h0, LPMC_OFS_CTRL, LPMC_WORD_ZERO);
        chk(q, LPMC_WORD_ZERO);
        apb(1'h0, LPMC_OFS_STS, LPMC_WORD_ZERO);
        chk(q[9:0], 10'h103);
        apb(1'h1, LPMC_OFS_CTRL, 32'h0000_0002);
        core_wait(1'h0, 1'h1);
        chk({CORE_POWER_EN, CORE_CLK_EN}, 2'h3);
        {WAKE_PIN, CORE_DEEP_SLEEP} = 3'h0;
        apb(1'h1, LPMC_OFS_CTRL, 32'h0000_000C);
        apb(1'h0, LPMC_OFS_STS, LPMC_WORD_ZERO);
        chk(q[1:0], 2'h0);
        pulse(RTC_ALARM);
        apb(1'h0, LPMC_OFS_STS, LPMC_WORD_ZERO);
        chk(q[0], 1'h1);
    endtask
    // one standby round, woken by a single-cycle pulse on one wake source
    task automatic sb_round(ref logic s, input logic lvl);
        apb(1'h1, LPMC_OFS_CTRL, 32'h0000_0002);
        core_wait(1'h0, 1'h1);
        chk(CORE_POWER_EN, 1'h0);
        s = lvl;
        @(negedge SYS_CLK);
        s = !lvl;
        wait_hi(CHIP_RESET_REQ, 10);
        wait_hi(WAKE_REQ, 200);
    endtask
    task automatic t_wake;
        {CORE_SLEEP_ON_EXIT, CORE_IN_ISR} = 2'h3;
        core_wait(1'h0, 1'h0);
        chk(CORE_CLK_EN, 1'h1);
        CORE_IN_ISR = 1'h0;
        repeat (2) @(negedge SYS_CLK);
        chk({CORE_CLK_EN, DOMAIN_CLK_EN}, 2'h1);
        pulse(irq_req);
        wait_hi(WAKE_REQ, 20);
        chk(WAKE_TO_ISR, 1'h1);
        CORE_SLEEP_ON_EXIT = 1'h0;
        core_wait(1'h1, 1'h0);
        pulse(EVENT_IN);
        wait_hi(WAKE_REQ, 20);
        chk({CORE_CLK_EN, WAKE_TO_ISR}, 2'h2);
        // alarm left the wake flag set, which would refuse standby
        apb(1'h1, LPMC_OFS_CTRL, 32'h0000_0004);
        sb_round(RTC_EVENT, 1'h1);
        sb_round(EXT_RESET_PIN_N, 1'h0);
        sb_round(WATCHDOG_RESET, 1'h1);
        apb(1'h1, LPMC_OFS_CTRL, 32'h0000_0100);
        RST_N = 1'h0;
        @(negedge SYS_CLK);
        RST_N = 1'h1;
        chk(RTC_WRITE_EN, 1'h0);
        apb(1'h0, LPMC_OFS_STS, LPMC_WORD_ZERO);
        chk(q[9:8], 2'h0);
        chk(q[1], 1'h1);
        POR_N = 1'h0;
        @(negedge SYS_CLK);
        POR_N = 1'h1;
        apb(1'h0, LPMC_OFS_STS, LPMC_WORD_ZERO);
        chk(q[1], 1'h0);
    endtask
    task automatic end_sim;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        {RST_N, POR_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = 49'h0;
        {CORE_WAIT_EVENT, CORE_DEEP_SLEEP, CORE_SLEEP_ON_EXIT, CORE_IN_ISR} = 4'h0;
        {EVENT_IN, RTC_ALARM, RTC_EVENT, WATCHDOG_RESET, go, irq_req, WAKE_PIN} = 8'h0;
        EXT_RESET_PIN_N = 1'h1;
        repeat (6) @(negedge SYS_CLK);
        {RST_N, POR_N} = 2'h3;
        t_regs;
        t_sleep;
        t_stop;
        t_standby;
        t_wake;
        end_sim;
    end
    initial begin
        #200000;
        n_fail++;
        end_sim;
    end
endmodule
